//--- inc/rect_addr_pkg.sv
// Constants shared by the rectifier address and output control logic.
package rect_addr_pkg;
  // APB register byte offsets.
  localparam logic [11:0] OFS_VOUT_CMD = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_POSITION = 12'h008;
  localparam logic [11:0] OFS_EVENT = 12'h00C;
  localparam logic [11:0] OFS_IDENT = 12'h010;
  // Identity word, value is arbitrary.
  localparam logic [31:0] IDENT_VALUE = 32'h0000_A5A5;
  // Status register field positions.
  localparam int ST_MD_MODE = 0;
  localparam int ST_ADDR_OK = 1;
  localparam int ST_MAIN_ON = 2;
  localparam int ST_FW_OWNS = 3;
  localparam int ST_VOUT_DFLT = 4;
  localparam int ST_BAD_CMD = 5;
  localparam int ST_ADDR_LSB = 8;
  // Position register field positions.
  localparam int POS_UNIT_LSB = 0;
  localparam int POS_RACK_LSB = 4;
  localparam int POS_SLOT_LSB = 8;
  localparam int POS_SHELF_LSB = 12;
  // Event register bit: invalid command seen, write one to clear.
  localparam int EV_BAD_CMD = 0;
  // Level codes: 8 bits, 3.3 V full scale for the 3.3 V strap inputs.
  // Unit and slot: ten positions, code at or above the first entry is invalid.
  localparam logic [79:0] UNIT_TH = {8'hF3, 8'hDB, 8'hC2, 8'hA8, 8'h8F,
                                     8'h75, 8'h5C, 8'h42, 8'h29, 8'h0E};
  // Rack: eight positions from 3.3 V down to 0 V.
  localparam logic [55:0] RACK_TH = {8'hEC, 8'hC5, 8'h9E, 8'h7C, 8'h5D,
                                     8'h3A, 8'h13};
  // Slot position that means tied to main return.
  localparam logic [3:0] SLOT_TIED = 4'hA;
  // Shelf code is 20 codes (about 0.26 V) per step; windows of shelf one to ten.
  localparam logic [79:0] SHELF_MIN = {8'hBF, 8'hAB, 8'h98, 8'h85, 8'h72,
                                       8'h5F, 8'h4C, 8'h3C, 8'h26, 8'h13};
  localparam logic [79:0] SHELF_MAX = {8'hD2, 8'hBC, 8'hA8, 8'h93, 8'h7E,
                                       8'h69, 8'h54, 8'h3C, 8'h2A, 8'h15};
  // Programming pin code above 3 V selects the default voltage.
  localparam logic [7:0] VPROG_DFLT_TH = 8'hE7;
  localparam logic [7:0] VOUT_DEFAULT = 8'h80;
  // Serial address: upper bits and broadcast value.
  localparam logic [2:0] SER_ADDR_TOP = 3'h4;
  localparam logic [6:0] BCAST_ADDR = 7'h00;
endpackage : rect_addr_pkg

//--- verilog/strap_sync.sv
// Three-stage synchroniser that passes a value once stages two and three agree.
module strap_sync #(
  parameter int W = 8
) (
  // Clock, reset and enable.
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  // Raw and filtered values.
  input wire logic [W-1:0] raw_i,
  output logic [W-1:0] filt_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } sync_st_t;

  sync_st_t st;
  sync_st_t next_st;

  // The first stage feeds only the second; the output moves on agreement.
  always_comb begin
    next_st = st;
    next_st.s1 = raw_i;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    if (st.s2 == st.s3) begin
      next_st.q = st.s3;
    end
  end

  // State register, frozen while the enable is low.
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st <= '0;
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  assign filt_o = st.q;
endmodule : strap_sync

//--- verilog/rect_addr_ctrl.sv
// Strap decoding, bus address matching and main output control.
//
// Functional notes
// - Answer 100 plus address bits, and broadcast zero.
// - Protocol strap selects serial or multi-drop.
// - Rack level quantised to eight positions.
// - Address bits from unit and rack table.
// - Unit and slot: ten positions, 3.3V invalid.
// - Shelf identified by ten tolerance windows.
// - Multi-drop address is bay, slot, shelf.
// - Bay identity reuses decoded unit position.
// - Slot tied to return is second interlock in serial mode; multi-drop needs any valid slot.
// - Broadcast write acts; broadcast read flags invalid.
// - Every serial-mode unit acknowledges broadcast ninth bit.
// - Pin sets voltage until software command executes.
// - Bias power cycle restores pin control.
// - Pin above 3V selects default voltage.
// - Serial mode: output on only with on/off low.
// - Release of interlock, or of on/off in serial mode, turns off.
// - Multi-drop mode ignores the on/off input.
// - Output stays off unless interlock is connected.
module rect_addr_ctrl (
  // Clock, reset and enable.
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  // Digitised strap levels.
  input wire logic [7:0] unit_position_input_i,
  input wire logic [7:0] rack_position_input_i,
  input wire logic [7:0] slot_position_input_i,
  input wire logic [7:0] shelf_position_input_i,
  input wire logic [7:0] vprog_level_i,
  // Digital control pins.
  input wire logic protocol_resistor_i,
  input wire logic on_off_b_i,
  input wire logic interlock_b_i,
  // Received address byte from the serial engine.
  input wire logic [7:0] addr_byte_i,
  input wire logic addr_stb_i,
  // APB slave.
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Serial address answer.
  output logic addr_ack_o,
  output logic bcast_write_o,
  // Output control and identity.
  output logic main_on_o,
  output logic [7:0] vout_setting_o,
  output logic [11:0] multidrop_addr_o
);
  typedef struct packed {
    logic [3:0] unit_pos;
    logic [3:0] rack_pos;
    logic [3:0] slot_pos;
    logic [3:0] shelf_pos;
    logic md_mode;
    logic addr_ok;
    logic [3:0] addr;
    logic main_on;
    logic fw_owns;
    logic [7:0] fw_vout;
    logic [7:0] vout;
    logic vout_dflt;
    logic bad_cmd;
    logic ack;
    logic bcast_wr;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } ctrl_st_t;

  ctrl_st_t st;
  ctrl_st_t next_st;
  logic [39:0] lvl_s;
  logic [2:0] pin_s;
  logic [7:0] unit_s;
  logic [7:0] rack_s;
  logic [7:0] slot_s;
  logic [7:0] shelf_s;
  logic [7:0] vprog_s;
  logic proto_s;
  logic onoff_b_s;
  logic ilock_b_s;
  logic apb_done;
  logic [4:0] map;
  logic [31:0] status_w;
  logic [31:0] pos_w;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers.

  // Strap levels and pins come from outside the clock domain.
  strap_sync #(.W(40)) u_lvl_sync (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .raw_i({unit_position_input_i, rack_position_input_i, slot_position_input_i,
            shelf_position_input_i, vprog_level_i}),
    .filt_o(lvl_s)
  );

  strap_sync #(.W(3)) u_pin_sync (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .raw_i({protocol_resistor_i, on_off_b_i, interlock_b_i}),
    .filt_o(pin_s)
  );

  // Split the filtered vectors.
  assign {unit_s, rack_s, slot_s, shelf_s, vprog_s} = lvl_s;
  assign {proto_s, onoff_b_s, ilock_b_s} = pin_s;

  ////////////////////////////////////////////////////////////////////////////
  // Decode functions.

  // Counts thresholds that the code lies below; used for three inputs.
  function automatic logic [3:0] below_count(input logic [7:0] code,
                                             input logic [79:0] th,
                                             input int n);
    logic [3:0] cnt;
    cnt = 4'h0;
    for (int k = 0; k < n; k++) begin
      if (code < th[8*k +: 8]) begin
        cnt = cnt + 4'h1;
      end
    end
    return cnt;
  endfunction : below_count

  // Finds the shelf window holding the code; zero when none does.
  function automatic logic [3:0] shelf_of(input logic [7:0] code);
    logic [3:0] pos;
    pos = 4'h0;
    for (int k = 0; k < 10; k++) begin
      if (code >= rect_addr_pkg::SHELF_MIN[8*k +: 8] &&
          code <= rect_addr_pkg::SHELF_MAX[8*k +: 8]) begin
        pos = 4'(k + 1);
      end
    end
    return pos;
  endfunction : shelf_of

  // Maps unit and rack positions to {valid, address bits}.
  function automatic logic [4:0] addr_of(input logic [3:0] unit,
                                         input logic [3:0] rack);
    logic [4:0] res;
    logic [5:0] seq;
    res = 5'h00;
    seq = 6'h00;
    if (rack >= 4'h1 && rack <= 4'h4 && unit >= 4'h1 && unit <= 4'h4) begin
      res = {1'h1, 2'(rack - 4'h1), 2'(unit - 4'h1)};
    end else if (rack >= 4'h6 && rack <= 4'h8 && unit >= 4'h1 && unit <= 4'h5) begin
      seq = 6'((rack - 4'h6) * 4'h5) + 6'(unit - 4'h1);
      res = {1'h1, seq[3:0]};
    end
    return res;
  endfunction : addr_of

  ////////////////////////////////////////////////////////////////////////////
  // Register views.

  assign map = addr_of(st.unit_pos, st.rack_pos);
  assign apb_done = psel_i && penable_i && st.pready;

  // Status and position words read over the bus.
  always_comb begin
    status_w = 32'h0000_0000;
    status_w[rect_addr_pkg::ST_MD_MODE] = st.md_mode;
    status_w[rect_addr_pkg::ST_ADDR_OK] = st.addr_ok;
    status_w[rect_addr_pkg::ST_MAIN_ON] = st.main_on;
    status_w[rect_addr_pkg::ST_FW_OWNS] = st.fw_owns;
    status_w[rect_addr_pkg::ST_VOUT_DFLT] = st.vout_dflt;
    status_w[rect_addr_pkg::ST_BAD_CMD] = st.bad_cmd;
    status_w[rect_addr_pkg::ST_ADDR_LSB +: 4] = st.addr;
    pos_w = 32'h0000_0000;
    pos_w[rect_addr_pkg::POS_UNIT_LSB +: 4] = st.unit_pos;
    pos_w[rect_addr_pkg::POS_RACK_LSB +: 4] = st.rack_pos;
    pos_w[rect_addr_pkg::POS_SLOT_LSB +: 4] = st.slot_pos;
    pos_w[rect_addr_pkg::POS_SHELF_LSB +: 4] = st.shelf_pos;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  always_comb begin
    next_st = st;
    next_st.ack = 1'h0;
    next_st.bcast_wr = 1'h0;
    // Position decode of every strap.
    next_st.unit_pos = below_count(unit_s, rect_addr_pkg::UNIT_TH, 10);
    next_st.slot_pos = below_count(slot_s, rect_addr_pkg::UNIT_TH, 10);
    next_st.rack_pos = below_count(rack_s, {24'h00_0000, rect_addr_pkg::RACK_TH}, 7)
                       + 4'h1;
    next_st.shelf_pos = shelf_of(shelf_s);
    next_st.md_mode = proto_s;
    next_st.addr_ok = map[4];
    next_st.addr = map[3:0];
    // Output on needs interlock and slot; on/off counts in serial mode only.
    if (st.md_mode) begin
      next_st.main_on = !ilock_b_s && st.slot_pos != 4'h0;
    end else begin
      next_st.main_on = !ilock_b_s && !onoff_b_s &&
                        st.slot_pos == rect_addr_pkg::SLOT_TIED;
    end
    // Voltage source: software once it has spoken, else the pin.
    next_st.vout_dflt = !st.fw_owns && vprog_s > rect_addr_pkg::VPROG_DFLT_TH;
    if (st.fw_owns) begin
      next_st.vout = st.fw_vout;
    end else if (vprog_s > rect_addr_pkg::VPROG_DFLT_TH) begin
      next_st.vout = rect_addr_pkg::VOUT_DEFAULT;
    end else begin
      next_st.vout = vprog_s;
    end
    // Serial address match, only in serial-bus mode.
    if (addr_stb_i && !st.md_mode) begin
      if (addr_byte_i[7:1] == rect_addr_pkg::BCAST_ADDR) begin
        next_st.ack = 1'h1;
        next_st.bcast_wr = !addr_byte_i[0];
      end else if (st.addr_ok && addr_byte_i[7:5] == rect_addr_pkg::SER_ADDR_TOP &&
                   addr_byte_i[4:1] == st.addr) begin
        next_st.ack = 1'h1;
      end
    end
    // APB: answer one cycle into the access phase.
    next_st.pready = psel_i && penable_i && !st.pready;
    next_st.pslverr = 1'h0;
    next_st.prdata = 32'h0000_0000;
    if (psel_i && penable_i && !st.pready) begin
      case (paddr_i)
        rect_addr_pkg::OFS_VOUT_CMD: next_st.prdata = {24'h000000, st.fw_vout};
        rect_addr_pkg::OFS_STATUS: next_st.prdata = status_w;
        rect_addr_pkg::OFS_POSITION: next_st.prdata = pos_w;
        rect_addr_pkg::OFS_EVENT: next_st.prdata = {31'h0, st.bad_cmd};
        rect_addr_pkg::OFS_IDENT: next_st.prdata = rect_addr_pkg::IDENT_VALUE;
        default: next_st.pslverr = 1'h1;
      endcase
    end
    // Writes take effect at the completing edge.
    if (apb_done && pwrite_i) begin
      if (paddr_i == rect_addr_pkg::OFS_VOUT_CMD) begin
        next_st.fw_vout = pwdata_i[7:0];
        next_st.fw_owns = 1'h1;
      end
      if (paddr_i == rect_addr_pkg::OFS_EVENT && pwdata_i[rect_addr_pkg::EV_BAD_CMD]) begin
        next_st.bad_cmd = 1'h0;
      end
    end
    // A broadcast read sets the flag, winning over a clear.
    if (addr_stb_i && !st.md_mode && addr_byte_i == {rect_addr_pkg::BCAST_ADDR, 1'h1}) begin
      next_st.bad_cmd = 1'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.

  // Reset is the controller bias cycle; it returns voltage to the pin.
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st <= '0;
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register.
  assign prdata_o = st.prdata;
  assign pready_o = st.pready;
  assign pslverr_o = st.pslverr;
  assign addr_ack_o = st.ack;
  assign bcast_write_o = st.bcast_wr;
  assign main_on_o = st.main_on;
  assign vout_setting_o = st.vout;
  assign multidrop_addr_o = {st.unit_pos, st.slot_pos, st.shelf_pos};

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);

  // Broadcast address is acknowledged in serial mode.
  bcast_ack_a: assert property (
    ce_i && addr_stb_i && !st.md_mode && addr_byte_i[7:1] == 7'h00 |=> addr_ack_o)
    else $error("Broadcast address not acknowledged.");

  // Own address is acknowledged when configured.
  own_addr_a: assert property (
    ce_i && addr_stb_i && !st.md_mode && st.addr_ok && addr_byte_i[7:5] == 3'h4 &&
    addr_byte_i[4:1] == st.addr |=> addr_ack_o)
    else $error("Own address not acknowledged.");

  // Unconfigured units never answer a unit address.
  unconfig_quiet_a: assert property (
    ce_i && addr_stb_i && !st.addr_ok && addr_byte_i[7:5] == 3'h4 |=> !addr_ack_o)
    else $error("Unconfigured unit answered.");

  // Broadcast read raises the invalid flag and no write pulse.
  bcast_read_a: assert property (
    ce_i && addr_stb_i && !st.md_mode && addr_byte_i == 8'h01 |=> st.bad_cmd && !bcast_write_o)
    else $error("Broadcast read not flagged.");

  // Software ownership of the voltage holds until reset; the setting lags the command by one.
  fw_sticky_a: assert property (
    st.fw_owns |=> st.fw_owns && (!$past(ce_i) || vout_setting_o == $past(st.fw_vout)))
    else $error("Software voltage ownership lost.");

  // High pin level selects the default voltage.
  vout_default_a: assert property (
    ce_i && !st.fw_owns && vprog_s > 8'hE7 |=> vout_setting_o == 8'h80)
    else $error("Default voltage not selected.");

  // Released interlock turns the output off.
  ilock_off_a: assert property (
    ce_i && ilock_b_s |=> !main_on_o)
    else $error("Output on with interlock released.");

  // Serial mode needs on/off low.
  onoff_off_a: assert property (
    ce_i && !st.md_mode && onoff_b_s |=> !main_on_o)
    else $error("Output on with on/off released.");

  // Multi-drop mode ignores on/off.
  md_ignore_a: assert property (
    ce_i && st.md_mode && !ilock_b_s && st.slot_pos != 4'h0 |=> main_on_o)
    else $error("Multi-drop output not on.");

  // Zero volt rack is position eight.
  rack_low_a: assert property (
    ce_i && rack_s == 8'h00 |=> st.rack_pos == 4'h8)
    else $error("Rack position wrong.");

  bcast_write_c: cover property (bcast_write_o);
  fw_take_c: cover property (!st.fw_owns ##1 st.fw_owns);
  main_on_c: cover property (!main_on_o ##1 main_on_o);
endmodule : rect_addr_ctrl

//--- tb/host_master_model.sv
// Host bus master model that offers address bytes to the serial address decoder.
module host_master_model (
  // Clock.
  input wire logic clk_i,
  // Answers from the device.
  input wire logic ack_i,
  input wire logic bcast_write_i,
  // Address byte towards the device.
  output logic [7:0] addr_byte_o,
  output logic addr_stb_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus at time zero.
  initial begin
    addr_byte_o = 8'hA5;
    addr_stb_o = 1'h0;
  end

  // Sends one byte and returns the answers seen in the cycle after the strobe.
  // Reads at the broadcast byte go out like any other byte; the bench sends one to check the invalid flag.
  task automatic send(input logic [7:0] b, output logic ack, output logic bc);
    @(posedge clk_i);
    addr_byte_o <= b;
    addr_stb_o <= 1'h1;
    @(posedge clk_i);
    addr_stb_o <= 1'h0;
    addr_byte_o <= ~b;
    @(posedge clk_i);
    ack = ack_i;
    bc = bcast_write_i;
  endtask : send
endmodule : host_master_model

//--- tb/rectifier_address_and_output_control_test.sv
// Self-checking bench for the rectifier address and output control block.
module rectifier_address_and_output_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0;
  logic ce = 1'h1;
  logic rst_b = 1'h0;
  logic [7:0] unit = 8'h00, rack = 8'h00, slot = 8'h00, shelf = 8'h14, vprog = 8'hFF;
  logic proto = 1'h0, on_b = 1'h1, ilk_b = 1'h1, psel = 1'h0, pen = 1'h0, pwr = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'hFEAB64FF;
  logic [7:0] abyte, vout;
  logic astb, pready, pslverr, ack, bcw, main_on, ok, bc, err;
  logic [11:0] md_addr;
  logic [4:0] e;
  int err_total = 0, checks_done = 0, u, r, s, n;
  localparam logic [7:0] RACK_LV [1:8] = '{8'hFF, 8'hD8, 8'hB2, 8'h8B, 8'h6C, 8'h4D, 8'h27,
                                          8'h00};

  rect_addr_ctrl u_dut (.ref_clk_i(clk), .rst_b_i(rst_b), .ce_i(ce),
    .unit_position_input_i(unit), .rack_position_input_i(rack),
    .slot_position_input_i(slot), .shelf_position_input_i(shelf), .vprog_level_i(vprog),
    .protocol_resistor_i(proto), .on_off_b_i(on_b), .interlock_b_i(ilk_b),
    .addr_byte_i(abyte), .addr_stb_i(astb), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .addr_ack_o(ack), .bcast_write_o(bcw),
    .main_on_o(main_on), .vout_setting_o(vout), .multidrop_addr_o(md_addr));
  host_master_model u_host (.clk_i(clk), .ack_i(ack), .bcast_write_i(bcw),
    .addr_byte_o(abyte), .addr_stb_o(astb));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock source.
  initial begin
    forever #5 clk = ~clk;
  end

  // Next value of the stimulus generator.
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  // Level code of a unit or slot position; position zero means no resistor.
  function automatic logic [7:0] pos_code(input int p);
    return (p == 0) ? 8'hFF : 8'((10 - p) * 26);
  endfunction : pos_code

  // Expected {configured, address bits} for a unit and rack position.
  function automatic logic [4:0] exp_addr(input int pu, input int pr);
    if (pu == 0) return 5'h00;
    if (pr <= 4 && pu <= 4) return {1'h1, 2'(pr - 1), 2'(pu - 1)};
    if (pr >= 6 && pu <= 5) return {1'h1, 4'((pr - 6) * 5 + pu - 1)};
    return 5'h00;
  endfunction : exp_addr

  // Compares one value and counts the result.
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One APB transfer; holds the request until ready is sampled high.
  // Only the watchdog ends a wait that never completes.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pen <= 1'h0;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'h1;
    do begin
      @(posedge clk);
    end while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    pen <= 1'h0;
  endtask : apb

  // Lets pin changes pass the synchronisers and the decoder.
  task automatic settle;
    repeat (12) @(posedge clk);
  endtask : settle

  // Sends a serial address byte and checks both answers.
  task automatic ser(input logic [7:0] b, input logic eack, input logic ebc);
    u_host.send(b, ok, bc);
    chk("addr_ack", 32'(eack), 32'(ok));
    chk("bcast_write", 32'(ebc), 32'(bc));
  endtask : ser

  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict;
    $display("counts: %0d checks, %0d mismatches", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : give_verdict

  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog against a hung handshake.
  initial begin
    repeat (30000) @(posedge clk);
    err_total++;
    give_verdict();
  end

  // Main sequence.
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'h1;
    settle();
    apb(1'h0, 12'h014, 32'h0);
    chk("unmapped err", 32'h1, 32'(err));
    chk("unmapped data", 32'h0, rd);
    apb(1'h0, rect_addr_pkg::OFS_IDENT, 32'h0);
    chk("ident", rect_addr_pkg::IDENT_VALUE, rd);
    $display("test registers done");
    for (int i = 0; i < 14; i++) begin
      seed = lfsr(seed);
      u = seed[7:0] % 6;
      r = seed[15:8] % 8 + 1;
      if (i == 0) begin
        u = 5;
        r = 4;
      end
      unit <= pos_code(u);
      rack <= RACK_LV[r];
      settle();
      e = exp_addr(u, r);
      apb(1'h0, rect_addr_pkg::OFS_POSITION, 32'h0);
      chk("position", {24'h0, 4'(r), 4'(u % 10)}, {24'h0, rd[7:0]});
      apb(1'h0, rect_addr_pkg::OFS_STATUS, 32'h0);
      chk("addr_ok", 32'(e[4]), 32'(rd[rect_addr_pkg::ST_ADDR_OK]));
      if (e[4]) chk("addr bits", 32'(e[3:0]), 32'(rd[11:8]));
      ser({3'h4, e[3:0], 1'h1}, e[4], 1'h0);
      ser({3'h4, e[3:0] ^ 4'h1, 1'h0}, 1'h0, 1'h0);
    end
    unit <= pos_code(5);
    rack <= RACK_LV[8];
    settle();
    ser(8'h00, 1'h1, 1'h1);
    ser({3'h4, 4'hE, 1'h1}, 1'h1, 1'h0);
    apb(1'h0, rect_addr_pkg::OFS_EVENT, 32'h0);
    chk("event idle", 32'h0, 32'(rd[0]));
    ser(8'h01, 1'h1, 1'h0);
    apb(1'h0, rect_addr_pkg::OFS_EVENT, 32'h0);
    chk("event bad read", 32'h1, 32'(rd[0]));
    apb(1'h1, rect_addr_pkg::OFS_EVENT, 32'h1);
    apb(1'h0, rect_addr_pkg::OFS_EVENT, 32'h0);
    chk("event cleared", 32'h0, 32'(rd[0]));
    $display("test address done");
    for (int k = 0; k < 8; k++) begin
      ilk_b <= k[0];
      on_b <= k[1];
      slot <= k[2] ? pos_code(10) : pos_code(k[1] ? 0 : 3);
      settle();
      chk("main_on", 32'(k == 4), 32'(main_on));
    end
    $display("test output serial done");
    proto <= 1'h1;
    ilk_b <= 1'h0;
    for (int k = 0; k < 6; k++) begin
      seed = lfsr(seed);
      u = seed[7:0] % 10 + 1;
      s = seed[15:8] % 10 + 1;
      n = seed[23:16] % 10 + 1;
      unit <= pos_code(u);
      slot <= pos_code(s);
      shelf <= 8'(20 * n);
      on_b <= seed[24];
      settle();
      chk("md addr", {20'h0, 4'(u), 4'(s), 4'(n)}, 32'(md_addr));
      chk("main_on md", 32'h1, 32'(main_on));
    end
    ser(8'h00, 1'h0, 1'h0);
    slot <= pos_code(0);
    settle();
    chk("main_on no slot", 32'h0, 32'(main_on));
    proto <= 1'h0;
    $display("test multidrop done");
    for (int k = 0; k < 6; k++) begin
      seed = lfsr(seed);
      vprog <= k[0] ? (8'hF0 | seed[3:0]) : (seed[7:0] % 8'hE0);
      settle();
      chk("vout pin", k[0] ? 32'h80 : 32'(vprog), 32'(vout));
    end
    // With the enable low the setting must hold its last value.
    ce <= 1'h0;
    vprog <= 8'h10;
    settle();
    chk("vout frozen", 32'h80, 32'(vout));
    ce <= 1'h1;
    settle();
    chk("vout thawed", 32'h10, 32'(vout));
    apb(1'h1, rect_addr_pkg::OFS_VOUT_CMD, 32'h5A);
    vprog <= 8'h33;
    settle();
    chk("vout sw", 32'h5A, 32'(vout));
    apb(1'h0, rect_addr_pkg::OFS_VOUT_CMD, 32'h0);
    chk("vout readback", 32'h5A, rd);
    apb(1'h0, rect_addr_pkg::OFS_STATUS, 32'h0);
    chk("fw_owns", 32'h1, 32'(rd[rect_addr_pkg::ST_FW_OWNS]));
    rst_b <= 1'h0;
    repeat (2) @(posedge clk);
    chk("vout in reset", 32'h0, 32'(vout));
    rst_b <= 1'h1;
    settle();
    chk("vout after reset", 32'h33, 32'(vout));
    $display("test voltage done");
    give_verdict();
  end
endmodule : rectifier_address_and_output_control_test
